//--- design/dbk_block_ctrl.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "dbk_cfg.svh"
module dbk_block_ctrl (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Register bus.
  input wire dbk_pkg::dbk_axi_req_type axiReq,
  output dbk_pkg::dbk_axi_rsp_type axiRsp,
  // Serial receive pins from outside the clock domain.
  input wire logic rxData,
  input wire logic baudClk8x,
  // Neighbouring logic on the same clock.
  input wire logic [15:0] blockIrq,
  input wire logic [7:0] datapathStatus,
  input wire logic prevPrimary,
  // Block outputs.
  output logic irq,
  output logic blockEnable,
  output logic [7:0] functionControl,
  output logic [4:0] functionConfig,
  output logic deadBandRef,
  output logic [7:0] txHoldData,
  output logic txHoldLoad
);
  import dbk_pkg::*;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Writable control bits for each function.
  function automatic logic [7:0] rwMask(input logic [2:0] fn, input logic mode0);
    case (fn)
      `DBK_FN_TIMER: rwMask = `DBK_RW_TIMER;
      `DBK_FN_COUNTER: rwMask = `DBK_RW_COUNTER;
      `DBK_FN_CRC_PRS: rwMask = `DBK_RW_CRC_PRS;
      `DBK_FN_DEADBAND: rwMask = `DBK_RW_DEADBAND;
      `DBK_FN_SPI: rwMask = `DBK_RW_SPI;
      `DBK_FN_UART: rwMask = mode0 ? `DBK_RW_TX : `DBK_RW_RX;
      default: rwMask = `DBK_RW_COUNTER;
    endcase
  endfunction

  // Read-only status bits for each function.
  function automatic logic [7:0] roMask(input logic [2:0] fn, input logic mode0);
    case (fn)
      `DBK_FN_SPI: roMask = `DBK_RO_SPI;
      `DBK_FN_UART: roMask = mode0 ? `DBK_RO_TX : `DBK_RO_RX;
      default: roMask = 8'h00;
    endcase
  endfunction

  // Bits of a mask register that exist on this device shape.
  localparam logic [7:0] UpperExist = (`DBK_NUM_ROWS == 4) ? 8'hff : 8'h00;
  localparam logic [7:0] LowerExist = (`DBK_NUM_ROWS >= 2) ? 8'hff : 8'h0f;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic awHeld, wHeld, next_awHeld, next_wHeld;
  logic [7:0] awIdx, next_awIdx;
  logic [7:0] wByte, next_wByte;
  logic wLane, next_wLane;
  dbk_axi_rsp_type next_axiRsp;
  logic [7:0] ctrl, next_ctrl;
  logic [7:0] upperMask, next_upperMask, lowerMask, next_lowerMask;
  logic [7:0] pendLo, next_pendLo, pendHi, next_pendHi;
  logic [7:0] rxBuf, next_rxBuf, bitBangClk, next_bitBangClk;
  logic next_irq, next_blockEnable, next_deadBandRef, next_txHoldLoad;
  logic [7:0] next_functionControl, next_txHoldData;
  logic [4:0] next_functionConfig;
  logic rxdMeta, rxdSync, baudMeta, baudSync, baudPrev;
  dbk_rx_state_type rxState, next_rxState;
  logic [7:0] shifter, next_shifter;
  logic [2:0] tickCnt, next_tickCnt, bitCnt, next_bitCnt;
  logic parAcc, next_parAcc, parBad, next_parBad;
  logic rxFull, next_rxFull, overrun, next_overrun;
  logic frameErr, next_frameErr, parErr, next_parErr;
  logic ownEvent, next_ownEvent;

  // Decoded strobes shared between groups.
  logic wrFire, arFire, rxBufRead, ctrlRead, rxMode, tick, charDone;
  logic [7:0] rdIdx, ctrlView, rdValue;
  logic rdMapped, wrMapped;
  logic [15:0] sources;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Only the second stage is looked at; the edge detect uses the third.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rxdMeta <= 1'b1;
      rxdSync <= 1'b1;
      baudMeta <= 1'b0;
      baudSync <= 1'b0;
      baudPrev <= 1'b0;
    end else begin
      rxdMeta <= rxData;
      rxdSync <= rxdMeta;
      baudMeta <= baudClk8x;
      baudSync <= baudMeta;
      baudPrev <= baudSync;
    end
  end

  assign tick = baudSync & ~baudPrev;
  assign rxMode = (functionConfig[2:0] == `DBK_FN_UART) &
                  ~functionConfig[`DBK_CFG_MODE0];

  // Control view: stored writable bits plus live status bits.
  always_comb begin
    logic [7:0] roBits;
    roBits = datapathStatus;
    if (rxMode) begin
      roBits = {parErr, overrun, frameErr, rxState != DBK_RX_IDLE, rxFull, 3'b000};
    end
    ctrlView = (ctrl & rwMask(functionConfig[2:0], functionConfig[`DBK_CFG_MODE0])) |
               (roBits & roMask(functionConfig[2:0], functionConfig[`DBK_CFG_MODE0]));
  end

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  assign wrFire = awHeld & wHeld & ~axiRsp.bvalid;
  assign arFire = axiReq.arvalid & axiRsp.arready;
  assign rdIdx = axiReq.araddr[9:2];
  assign rxBufRead = arFire & (rdIdx == `DBK_IDX_RX_BUF);
  assign ctrlRead = arFire & (rdIdx == `DBK_IDX_CTRL);

  // Read decode; write-only and unused locations read as zero.
  always_comb begin
    rdMapped = 1'b1;
    case (rdIdx)
      `DBK_IDX_UPPER_MASK: rdValue = upperMask;
      `DBK_IDX_LOWER_MASK: rdValue = lowerMask;
      `DBK_IDX_FUNC_CFG: rdValue = {3'b000, functionConfig};
      `DBK_IDX_CTRL: rdValue = ctrlView;
      `DBK_IDX_TX_HOLD: rdValue = 8'h00;
      `DBK_IDX_RX_BUF: rdValue = rxBuf;
      `DBK_IDX_BITBANG: rdValue = bitBangClk;
      `DBK_IDX_PEND_LO: rdValue = pendLo;
      `DBK_IDX_PEND_HI: rdValue = pendHi;
      default: begin
        rdValue = 8'h00;
        rdMapped = 1'b0;
      end
    endcase
    case (awIdx)
      `DBK_IDX_UPPER_MASK, `DBK_IDX_LOWER_MASK, `DBK_IDX_FUNC_CFG, `DBK_IDX_CTRL,
      `DBK_IDX_TX_HOLD, `DBK_IDX_RX_BUF, `DBK_IDX_BITBANG, `DBK_IDX_PEND_LO,
      `DBK_IDX_PEND_HI: wrMapped = 1'b1;
      default: wrMapped = 1'b0;
    endcase
  end

  // Address and data are caught independently, so either may come first.
  always_comb begin
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awIdx = awIdx;
    next_wByte = wByte;
    next_wLane = wLane;
    next_axiRsp = axiRsp;
    if (axiReq.awvalid && axiRsp.awready) begin
      next_awHeld = 1'b1;
      next_awIdx = axiReq.awaddr[9:2];
    end
    if (axiReq.wvalid && axiRsp.wready) begin
      next_wHeld = 1'b1;
      next_wByte = axiReq.wdata[7:0];
      next_wLane = axiReq.wstrb[0];
    end
    if (axiRsp.bvalid && axiReq.bready) begin
      next_axiRsp.bvalid = 1'b0;
    end
    if (wrFire) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_axiRsp.bvalid = 1'b1;
      next_axiRsp.bresp = wrMapped ? `DBK_RESP_OKAY : `DBK_RESP_SLVERR;
    end
    if (axiRsp.rvalid && axiReq.rready) begin
      next_axiRsp.rvalid = 1'b0;
    end
    if (arFire) begin
      next_axiRsp.rvalid = 1'b1;
      next_axiRsp.rdata = {24'h000000, rdValue};
      next_axiRsp.rresp = rdMapped ? `DBK_RESP_OKAY : `DBK_RESP_SLVERR;
    end
    next_axiRsp.awready = ~next_awHeld;
    next_axiRsp.wready = ~next_wHeld;
    next_axiRsp.arready = ~next_axiRsp.rvalid;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awIdx <= 8'h00;
      wByte <= 8'h00;
      wLane <= 1'b0;
      axiRsp <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, bresp: `DBK_RESP_OKAY,
                  rresp: `DBK_RESP_OKAY, rdata: 32'h00000000, default: 1'b0};
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awIdx <= next_awIdx;
      wByte <= next_wByte;
      wLane <= next_wLane;
      axiRsp <= next_axiRsp;
    end
  end

  // --------------------------------------------------------------------------
  // Software registers and interrupts
  // --------------------------------------------------------------------------
  // Pending bits are sticky and write-one-to-clear; a new event beats the clear.
  always_comb begin
    logic wr;
    wr = wrFire & wLane;
    next_ctrl = ctrl;
    next_upperMask = upperMask;
    next_lowerMask = lowerMask;
    next_functionConfig = functionConfig;
    next_bitBangClk = bitBangClk;
    next_txHoldData = txHoldData;
    next_txHoldLoad = 1'b0;
    next_pendLo = pendLo;
    next_pendHi = pendHi;
    if (wr) begin
      case (awIdx)
        `DBK_IDX_UPPER_MASK: next_upperMask = wByte & UpperExist;
        `DBK_IDX_LOWER_MASK: next_lowerMask = wByte & LowerExist;
        `DBK_IDX_FUNC_CFG: next_functionConfig = wByte[4:0] & `DBK_CFG_RW_MASK;
        // Status bits are never stored; only this function's writable bits are.
        `DBK_IDX_CTRL: next_ctrl = wByte & rwMask(functionConfig[2:0],
                                                  functionConfig[`DBK_CFG_MODE0]);
        `DBK_IDX_TX_HOLD: begin
          if (!rxMode) begin
            next_txHoldData = wByte;
            next_txHoldLoad = 1'b1;
          end
        end
        `DBK_IDX_BITBANG: next_bitBangClk = wByte;
        `DBK_IDX_PEND_LO: next_pendLo = pendLo & ~wByte;
        `DBK_IDX_PEND_HI: next_pendHi = pendHi & ~wByte;
        default: next_ctrl = ctrl;
      endcase
    end
    sources = blockIrq;
    sources[`DBK_OWN_SRC] = blockIrq[`DBK_OWN_SRC] | ownEvent;
    next_pendLo = next_pendLo | (sources[7:0] & lowerMask & LowerExist);
    next_pendHi = next_pendHi | (sources[15:8] & upperMask & UpperExist);
    next_irq = |({next_pendHi, next_pendLo} & {next_upperMask, next_lowerMask});
    next_blockEnable = next_ctrl[`DBK_CR_ENABLE];
    next_functionControl = ctrlView;
    // Bit-bang replaces the normal reference with a firmware-driven source.
    next_deadBandRef = prevPrimary;
    if ((functionConfig[2:0] == `DBK_FN_DEADBAND) && ctrl[`DBK_CR_BB_EN]) begin
      next_deadBandRef = ctrl[`DBK_CR_BB_SEL] ? bitBangClk[0] : prevPrimary;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= `DBK_RESET_VAL;
      upperMask <= `DBK_RESET_VAL;
      lowerMask <= `DBK_RESET_VAL;
      functionConfig <= 5'h00;
      bitBangClk <= `DBK_RESET_VAL;
      txHoldData <= `DBK_RESET_VAL;
      txHoldLoad <= 1'b0;
      pendLo <= `DBK_RESET_VAL;
      pendHi <= `DBK_RESET_VAL;
      irq <= 1'b0;
      blockEnable <= 1'b0;
      functionControl <= `DBK_RESET_VAL;
      deadBandRef <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      upperMask <= next_upperMask;
      lowerMask <= next_lowerMask;
      functionConfig <= next_functionConfig;
      bitBangClk <= next_bitBangClk;
      txHoldData <= next_txHoldData;
      txHoldLoad <= next_txHoldLoad;
      pendLo <= next_pendLo;
      pendHi <= next_pendHi;
      irq <= next_irq;
      blockEnable <= next_blockEnable;
      functionControl <= next_functionControl;
      deadBandRef <= next_deadBandRef;
    end
  end

  // --------------------------------------------------------------------------
  // Asynchronous receiver
  // --------------------------------------------------------------------------
  // Bits are sampled on the eighth baud tick after the start-bit midpoint.
  // Errors clear on a control read, so a poll loop sees each error once.
  always_comb begin
    next_rxState = rxState;
    next_shifter = shifter;
    next_tickCnt = tickCnt;
    next_bitCnt = bitCnt;
    next_parAcc = parAcc;
    next_parBad = parBad;
    next_rxBuf = rxBuf;
    charDone = 1'b0;
    next_ownEvent = 1'b0;
    next_frameErr = frameErr & ~ctrlRead;
    next_parErr = parErr & ~ctrlRead;
    if (!(rxMode && ctrl[`DBK_CR_ENABLE])) begin
      next_rxState = DBK_RX_IDLE;
    end else if (tick) begin
      next_tickCnt = tickCnt + 3'd1;
      case (rxState)
        DBK_RX_IDLE: begin
          next_tickCnt = 3'd0;
          if (!rxdSync) begin
            next_rxState = DBK_RX_START;
          end
        end
        DBK_RX_START: begin
          if (tickCnt == `DBK_TICK_MID) begin
            next_tickCnt = 3'd0;
            next_bitCnt = 3'd0;
            next_parAcc = 1'b0;
            next_rxState = rxdSync ? DBK_RX_IDLE : DBK_RX_DATA;
            next_ownEvent = ~rxdSync & functionConfig[`DBK_CFG_MODE1];
          end
        end
        DBK_RX_DATA: begin
          if (tickCnt == `DBK_TICK_LAST) begin
            next_shifter = {rxdSync, shifter[7:1]};
            next_parAcc = parAcc ^ rxdSync;
            next_bitCnt = bitCnt + 3'd1;
            if (bitCnt == `DBK_BIT_LAST) begin
              next_parBad = 1'b0;
              next_rxState = ctrl[`DBK_CR_PAR_EN] ? DBK_RX_PARITY : DBK_RX_STOP;
            end
          end
        end
        DBK_RX_PARITY: begin
          if (tickCnt == `DBK_TICK_LAST) begin
            next_parBad = (parAcc ^ rxdSync) != ctrl[`DBK_CR_PAR_ODD];
            next_rxState = DBK_RX_STOP;
          end
        end
        DBK_RX_STOP: begin
          if (tickCnt == `DBK_TICK_LAST) begin
            charDone = 1'b1;
            next_rxBuf = shifter;
            next_frameErr = ~rxdSync | next_frameErr;
            next_parErr = parBad | next_parErr;
            next_ownEvent = ~functionConfig[`DBK_CFG_MODE1];
            next_rxState = DBK_RX_IDLE;
          end
        end
        default: next_rxState = DBK_RX_IDLE;
      endcase
    end
    next_rxFull = charDone | (rxFull & ~rxBufRead);
    next_overrun = (charDone & rxFull & ~rxBufRead) | (overrun & ~ctrlRead);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rxState <= DBK_RX_IDLE;
      shifter <= `DBK_RESET_VAL;
      tickCnt <= 3'd0;
      bitCnt <= 3'd0;
      parAcc <= 1'b0;
      parBad <= 1'b0;
      rxBuf <= `DBK_RESET_VAL;
      rxFull <= 1'b0;
      overrun <= 1'b0;
      frameErr <= 1'b0;
      parErr <= 1'b0;
      ownEvent <= 1'b0;
    end else begin
      rxState <= next_rxState;
      shifter <= next_shifter;
      tickCnt <= next_tickCnt;
      bitCnt <= next_bitCnt;
      parAcc <= next_parAcc;
      parBad <= next_parBad;
      rxBuf <= next_rxBuf;
      rxFull <= next_rxFull;
      overrun <= next_overrun;
      frameErr <= next_frameErr;
      parErr <= next_parErr;
      ownEvent <= next_ownEvent;
    end
  end

endmodule

//--- design/dbk_cfg.svh
`ifndef DBK_CFG_SVH
`define DBK_CFG_SVH

// ----------------------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define DBK_IDX_UPPER_MASK 8'hdf
`define DBK_IDX_LOWER_MASK 8'he1
`define DBK_IDX_FUNC_CFG 8'h20
`define DBK_IDX_CTRL 8'h21
`define DBK_IDX_TX_HOLD 8'h22
`define DBK_IDX_RX_BUF 8'h23
`define DBK_IDX_BITBANG 8'h24
`define DBK_IDX_PEND_LO 8'h30
`define DBK_IDX_PEND_HI 8'h31
`define DBK_ADDR_W 10
`define DBK_RESET_VAL 8'h00
`define DBK_RESP_OKAY 2'b00
`define DBK_RESP_SLVERR 2'b10

// ----------------------------------------------------------------------------
// Device shape and block position
// ----------------------------------------------------------------------------
`define DBK_NUM_ROWS 4
`define DBK_OWN_SRC 2

// ----------------------------------------------------------------------------
// Function codes and configuration fields
// ----------------------------------------------------------------------------
`define DBK_FN_TIMER 3'h0
`define DBK_FN_COUNTER 3'h1
`define DBK_FN_CRC_PRS 3'h2
`define DBK_FN_DEADBAND 3'h4
`define DBK_FN_UART 3'h5
`define DBK_FN_SPI 3'h6
`define DBK_CFG_MODE0 3
`define DBK_CFG_MODE1 4
`define DBK_CFG_RW_MASK 5'h1f

// ----------------------------------------------------------------------------
// Control register fields and per-function access masks
// ----------------------------------------------------------------------------
`define DBK_CR_ENABLE 0
`define DBK_CR_PAR_EN 1
`define DBK_CR_PAR_ODD 2
`define DBK_CR_BB_EN 1
`define DBK_CR_BB_SEL 2
`define DBK_RW_TIMER 8'h07
`define DBK_RW_COUNTER 8'h01
`define DBK_RW_DEADBAND 8'h07
`define DBK_RW_CRC_PRS 8'h03
`define DBK_RW_SPI 8'h87
`define DBK_RO_SPI 8'h78
`define DBK_RW_TX 8'h07
`define DBK_RO_TX 8'h30
`define DBK_RW_RX 8'h07
`define DBK_RO_RX 8'hf8

// ----------------------------------------------------------------------------
// Receiver timing in ticks of the 8x baud clock
// ----------------------------------------------------------------------------
`define DBK_TICK_LAST 3'd7
`define DBK_TICK_MID 3'd3
`define DBK_BIT_LAST 3'd7

`endif

//--- design/dbk_pkg.sv
package dbk_pkg;

  // --------------------------------------------------------------------------
  // Bus carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [9:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [9:0] araddr;
    logic rready;
  } dbk_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dbk_axi_rsp_type;

  // --------------------------------------------------------------------------
  // Receiver sequence
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    DBK_RX_IDLE,
    DBK_RX_START,
    DBK_RX_DATA,
    DBK_RX_PARITY,
    DBK_RX_STOP
  } dbk_rx_state_type;

endpackage

//--- verification/dbk_block_ctrl_monitor.sv
`timescale 1ns/100ps
`include "dbk_cfg.svh"
// ----------------------------------------------------------------------------
// Port checker for the block control plane
// ----------------------------------------------------------------------------
module dbk_block_ctrl_monitor (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Register bus.
  input wire dbk_pkg::dbk_axi_req_type axiReq,
  input wire dbk_pkg::dbk_axi_rsp_type axiRsp,
  // Block pins.
  input wire logic [15:0] blockIrq,
  input wire logic irq,
  input wire logic blockEnable,
  input wire logic [7:0] functionControl,
  input wire logic [4:0] functionConfig,
  input wire logic txHoldLoad
);
  import dbk_pkg::*;

  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // The line rises one cycle after a source or with a mask write; the own receiver
  // event is internal and invisible here, so serial function is let through.
  property p_irq_cause;
    $rose(irq) |-> $past(blockIrq) != 16'h0000 || axiRsp.bvalid
      || functionConfig[2:0] == `DBK_FN_UART;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose without a source");

  // The enable only moves as a register write completes.
  property p_enable_sync;
    $changed(blockEnable) |-> axiRsp.bvalid || $past(axiRsp.bvalid);
  endproperty
  a_enable_sync: assert property (p_enable_sync) else $error("enable moved off a write");

  // Reads answer one cycle after the address is taken.
  property p_read_answer;
    axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid && !axiRsp.arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");

  // A taken read frees the channel on the next edge.
  property p_read_close;
    axiRsp.rvalid && axiReq.rready |=> !axiRsp.rvalid && axiRsp.arready;
  endproperty
  a_read_close: assert property (p_read_close) else $error("read not closed");

  // Address and data taken together give a response two edges later.
  property p_write_answer;
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
      |=> !axiRsp.bvalid ##1 axiRsp.bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer off");

  // Registers are eight bits wide.
  property p_read_width;
    axiRsp.rvalid |-> axiRsp.rdata[31:8] == 24'h000000;
  endproperty
  a_read_width: assert property (p_read_width) else $error("upper read bits set");

  // The holding register loads with the write response and never while receiving.
  property p_tx_load;
    txHoldLoad |-> axiRsp.bvalid
      && !(functionConfig[2:0] == `DBK_FN_UART && !functionConfig[`DBK_CFG_MODE0]);
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("holding load misplaced");

  // A counter keeps only its enable bit; the view lags the function by one cycle.
  property p_counter_bits;
    $past(functionConfig[2:0]) == `DBK_FN_COUNTER |-> functionControl[7:1] == 7'h00;
  endproperty
  a_counter_bits: assert property (p_counter_bits) else $error("counter extra bits");

  // The transmitter exposes no receive flags.
  property p_tx_bits;
    $past(functionConfig[2:0]) == `DBK_FN_UART && $past(functionConfig[`DBK_CFG_MODE0])
      |-> functionControl[7:6] == 2'b00 && !functionControl[3];
  endproperty
  a_tx_bits: assert property (p_tx_bits) else $error("transmitter bits wrong");
endmodule

bind dbk_block_ctrl dbk_block_ctrl_monitor i_dbk_block_ctrl_monitor (
  .sys_clk(sys_clk), .resetn(resetn), .axiReq(axiReq), .axiRsp(axiRsp),
  .blockIrq(blockIrq), .irq(irq), .blockEnable(blockEnable),
  .functionControl(functionControl), .functionConfig(functionConfig), .txHoldLoad(txHoldLoad)
);

//--- verification/tb.sv
`timescale 1ns/100ps
`include "dbk_cfg.svh"
// ----------------------------------------------------------------------------
// Register level testbench
// ----------------------------------------------------------------------------
module tb;
  import dbk_pkg::*;
  logic sys_clk;
  logic resetn;
  dbk_axi_req_type req;
  dbk_axi_rsp_type rsp;
  logic rxData;
  logic baudClk8x;
  logic [2:0] baudCnt;
  logic [15:0] blockIrq;
  logic irq;
  logic blockEnable;
  logic [7:0] functionControl;
  logic [4:0] functionConfig;
  logic [7:0] txHoldData;
  logic deadBandRef;
  logic [31:0] rdVal;
  logic [1:0] rdResp;
  int mismatches;
  int num_checks;
  logic [4:0] cfgTab [7];
  logic [7:0] expTab [7];

  // Status lines of outside datapaths stay fixed so their read-only view is known.
  dbk_block_ctrl i_dbk_block_ctrl (
    .sys_clk(sys_clk), .resetn(resetn), .axiReq(req), .axiRsp(rsp), .rxData(rxData),
    .baudClk8x(baudClk8x), .blockIrq(blockIrq), .datapathStatus(8'h30), .prevPrimary(1'b1),
    .irq(irq), .blockEnable(blockEnable), .functionControl(functionControl),
    .functionConfig(functionConfig), .deadBandRef(deadBandRef),
    .txHoldData(txHoldData), .txHoldLoad()
  );

  // System clock.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Baud tick clock at one eighth of the system clock, four cycles per level.
  always @(posedge sys_clk) begin
    baudCnt <= baudCnt + 3'h1;
    baudClk8x <= baudCnt[2];
  end

  // Comparison with counting.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
      mismatches++;
    end
  endtask

  // Verdict and end of run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // A bus wait that ran out ends the run.
  task automatic timeout();
    mismatches++;
    $display("unexpected bus wait expected answer seen none");
    conclude();
  endtask

  // Write: address and data offered together, each dropped once taken.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    int n;
    logic ta;
    logic tw;
    logic tr;
    n = 0;
    tr = 1'b0;
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= {idx, 2'b00};
    req.wvalid <= 1'b1;
    req.wdata <= {24'h000000, d};
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    while (!tr) begin
      @(negedge sys_clk);
      ta = req.awvalid && rsp.awready;
      tw = req.wvalid && rsp.wready;
      tr = rsp.bvalid;
      @(posedge sys_clk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (tr) req.bready <= 1'b0;
      n++;
      if (n > 50) timeout();
    end
  endtask

  // Read: the answer is sampled half a cycle before the edge that takes it.
  task automatic rd(input logic [7:0] idx);
    int n;
    logic ta;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr <= {idx, 2'b00};
    req.rready <= 1'b1;
    while (!got) begin
      @(negedge sys_clk);
      ta = req.arvalid && rsp.arready;
      got = rsp.rvalid;
      rdVal = rsp.rdata;
      rdResp = rsp.rresp;
      @(posedge sys_clk);
      if (ta) req.arvalid <= 1'b0;
      if (got) req.rready <= 1'b0;
      n++;
      if (n > 50) timeout();
    end
  endtask

  // Read and compare one register.
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    rd(idx);
    chk($sformatf("register %h", idx), rdVal, {24'h000000, exp});
  endtask

  // One-cycle pulse on the interrupt sources.
  task automatic pulse(input logic [15:0] v);
    @(posedge sys_clk);
    blockIrq <= v;
    @(posedge sys_clk);
    blockIrq <= 16'h0000;
    repeat (4) @(posedge sys_clk);
  endtask

  // Serial character: start, eight bits low first, stop; eight ticks each.
  task automatic sendChar(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      rxData <= fr[i];
      repeat (63) @(posedge sys_clk);
    end
    repeat (16) @(posedge sys_clk);
  endtask

  // Guard against a hang anywhere.
  initial begin
    repeat (20000) @(posedge sys_clk);
    timeout();
  end

  // Main sequence.
  initial begin
    resetn = 1'b0;
    req = '0;
    rxData = 1'b1;
    baudCnt = 3'h0;
    baudClk8x = 1'b0;
    blockIrq = 16'h0000;
    mismatches = 0;
    num_checks = 0;
    cfgTab = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h06, 5'h0d, 5'h05};
    expTab = '{8'h07, 8'h01, 8'h03, 8'h07, 8'hb7, 8'h37, 8'h07};
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rdc(`DBK_IDX_UPPER_MASK, 8'h00);
    rdc(`DBK_IDX_LOWER_MASK, 8'h00);
    rdc(`DBK_IDX_CTRL, 8'h00);
    wr(`DBK_IDX_UPPER_MASK, 8'ha5);
    rdc(`DBK_IDX_UPPER_MASK, 8'ha5);
    wr(`DBK_IDX_LOWER_MASK, 8'h5a);
    rdc(`DBK_IDX_LOWER_MASK, 8'h5a);
    rd(8'hff);
    chk("unmapped", {30'h0, rdResp}, {30'h0, `DBK_RESP_SLVERR});
    $display("test registers done");
    wr(`DBK_IDX_LOWER_MASK, 8'h00);
    wr(`DBK_IDX_UPPER_MASK, 8'h00);
    pulse(16'h0001);
    rdc(`DBK_IDX_PEND_LO, 8'h00);
    wr(`DBK_IDX_LOWER_MASK, 8'h01);
    pulse(16'h0001);
    chk("irq set", {31'h0, irq}, 32'h1);
    rdc(`DBK_IDX_PEND_LO, 8'h01);
    wr(`DBK_IDX_PEND_LO, 8'h01);
    repeat (3) @(posedge sys_clk);
    chk("irq clear", {31'h0, irq}, 32'h0);
    wr(`DBK_IDX_UPPER_MASK, 8'h80);
    pulse(16'h8000);
    rdc(`DBK_IDX_PEND_HI, 8'h80);
    wr(`DBK_IDX_PEND_HI, 8'h80);
    $display("test interrupts done");
    // Clearing the control word first keeps old bits out of the next function.
    for (int i = 0; i < 7; i++) begin
      wr(`DBK_IDX_CTRL, 8'h00);
      wr(`DBK_IDX_FUNC_CFG, {3'h0, cfgTab[i]});
      wr(`DBK_IDX_CTRL, 8'hff);
      rdc(`DBK_IDX_CTRL, expTab[i]);
      chk("enable", {31'h0, blockEnable}, 32'h1);
      chk("dead band ref", {31'h0, deadBandRef}, {31'h0, i != 3});
      wr(`DBK_IDX_TX_HOLD, 8'(i + 1));
    end
    chk("tx hold", {24'h0, txHoldData}, 32'h6);
    $display("test functions done");
    wr(`DBK_IDX_CTRL, 8'h01);
    sendChar(8'h3a);
    rdc(`DBK_IDX_CTRL, 8'h09);
    wr(`DBK_IDX_TX_HOLD, 8'h3c);
    wr(`DBK_IDX_RX_BUF, 8'h00);
    rdc(`DBK_IDX_RX_BUF, 8'h3a);
    rdc(`DBK_IDX_CTRL, 8'h01);
    chk("tx hold rx", {24'h0, txHoldData}, 32'h6);
    sendChar(8'h61);
    sendChar(8'hc3);
    rdc(`DBK_IDX_CTRL, 8'h49);
    rdc(`DBK_IDX_RX_BUF, 8'hc3);
    rdc(`DBK_IDX_CTRL, 8'h01);
    // With its mask bit set, the block's own character event becomes pending.
    wr(`DBK_IDX_LOWER_MASK, 8'h04);
    sendChar(8'h55);
    rdc(`DBK_IDX_PEND_LO, 8'h04);
    chk("irq own", {31'h0, irq}, 32'h1);
    $display("test receiver done");
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rdc(`DBK_IDX_LOWER_MASK, 8'h00);
    $display("test reset done");
    conclude();
  end
endmodule
